// >>> tccp_pkg.sv
// Summary of operation
// - address strap high enables the serial control port at target address 0x67.
// - address strap low enables the serial control port at target address 0x47.
// - address strap open disables the serial port; shared pins become status outputs.
// - in serial mode the interrupt pin pulls low when visible registers change.
// - in status mode the audio pin pulls low while an audio accessory is attached.
// - cable supply fault pin pulls low while supply overcurrent is detected.
// - in serial mode data and clock pins carry the serial bus lines.
// - status mode sinking: first status low for 1.5 A or 3 A, high for 900 mA.
// - status mode sinking: second status low only for high current.
// - source attach pin pulls low on attach while sourcing, as a fixed source or as a dual-role port acting as source.
// - port logic runs only while its enable input is held low.
// - role strap sampled at enable fall with 5 V present and at soft reset.
// - status mode source: current strap low 900 mA, medium 1.5 A, high 3 A.
package tccp_pkg;

    // =====================================================================
    // tri-level strap codes from the pin comparators
    localparam logic [1:0] TCCP_LVL_LOW  = 2'h0;
    localparam logic [1:0] TCCP_LVL_OPEN = 2'h1;
    localparam logic [1:0] TCCP_LVL_HIGH = 2'h2;

    // =====================================================================
    // target addresses of the serial control port
    localparam logic [6:0] TCCP_ADDR_STRAP_HIGH = 7'h67;
    localparam logic [6:0] TCCP_ADDR_STRAP_LOW  = 7'h47;
    localparam logic [6:0] TCCP_ADDR_RESET      = 7'h00;

    // =====================================================================
    // port roles and current levels
    localparam logic [1:0] TCCP_ROLE_SINK   = 2'h0;
    localparam logic [1:0] TCCP_ROLE_DUAL   = 2'h1;
    localparam logic [1:0] TCCP_ROLE_SOURCE = 2'h2;
    localparam logic [1:0] TCCP_CUR_DEFAULT = 2'h0;
    localparam logic [1:0] TCCP_CUR_MEDIUM  = 2'h1;
    localparam logic [1:0] TCCP_CUR_HIGH    = 2'h2;

    // =====================================================================
    // synchroniser layout: bit positions inside the pin vector
    localparam int TCCP_SYNC_W   = 9;
    localparam int TCCP_POS_SCL  = 0;
    localparam int TCCP_POS_SDA  = 1;
    localparam int TCCP_POS_EN   = 2;
    localparam int TCCP_POS_CUR  = 3;
    localparam int TCCP_POS_ROLE = 5;
    localparam int TCCP_POS_ADDR = 7;
    localparam logic [TCCP_SYNC_W-1:0] TCCP_SYNC_RESET = 9'h007;

endpackage

// >>> tccp_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// two-stage synchroniser for a vector of pin levels
module tccp_sync2 #(
    parameter int                 WIDTH    = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// >>> tccp_pins.sv
`timescale 1ns/1ps
`default_nettype none

module tccp_pins
    import tccp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // =====================================================================
    // strap and enable pins (asynchronous)
    input  wire logic [1:0] addr_strap_level,
    input  wire logic [1:0] role_strap_level,
    input  wire logic [1:0] current_strap_level,
    input  wire logic       cc_logic_enable_low,
    input  wire logic       supply_5v_present,
    input  wire logic       soft_reset,
    // port-state inputs from the detection logic (same clock)
    input  wire logic       cc_attach_detected,
    input  wire logic       cc_acting_source,
    input  wire logic       audio_detected,
    input  wire logic [1:0] sink_current_level,
    input  wire logic       cable_supply_overcurrent,
    input  wire logic       reg_change_pending,
    // serial target engine drive requests (same clock)
    input  wire logic       i2c_sda_drive_low,
    input  wire logic       i2c_scl_drive_low,
    // =====================================================================
    // shared data / first status pin
    input  wire logic       sda_pin_in,
    output var  logic       sda_pin_out,
    output var  logic       sda_pin_oe,
    // shared clock / second status pin
    input  wire logic       scl_pin_in,
    output var  logic       scl_pin_out,
    output var  logic       scl_pin_oe,
    // interrupt / audio_accessory_flag pin
    output var  logic       audio_accessory_flag_out,
    output var  logic       audio_accessory_flag_oe,
    output var  logic       cable_supply_overcurrent_low_out,
    output var  logic       cable_supply_overcurrent_low_oe,
    output var  logic       source_attach_low_out,
    output var  logic       source_attach_low_oe,
    // =====================================================================
    // configuration towards the rest of the port
    output var  logic       i2c_enable,
    output var  logic [6:0] i2c_target_addr,
    output var  logic       i2c_sda_in,
    output var  logic       i2c_scl_in,
    output var  logic       cc_active,
    output var  logic [1:0] port_role,
    output var  logic [1:0] advertise_current
);

    // =====================================================================
    // pin synchronisers
    logic [TCCP_SYNC_W-1:0] pins_sync;

    tccp_sync2 #(
        .WIDTH     (TCCP_SYNC_W),
        .RESET_VAL (TCCP_SYNC_RESET)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in ({addr_strap_level, role_strap_level, current_strap_level,
                    cc_logic_enable_low, sda_pin_in, scl_pin_in}),
        .sync_out (pins_sync)
    );

    wire logic [1:0] addr_s  = pins_sync[TCCP_POS_ADDR +: 2];
    wire logic [1:0] role_s  = pins_sync[TCCP_POS_ROLE +: 2];
    wire logic [1:0] cur_s   = pins_sync[TCCP_POS_CUR +: 2];
    wire logic       en_low_s = pins_sync[TCCP_POS_EN];

    // serial engine sees the synchronised bus lines directly
    assign i2c_sda_in = pins_sync[TCCP_POS_SDA];
    assign i2c_scl_in = pins_sync[TCCP_POS_SCL];

    // =====================================================================
    // strap sampling
    logic en_low_prev;
    logic init_done;

    // first sample right after reset release, then on each enable fall with 5 V present or soft reset
    wire logic en_fall     = en_low_prev & ~en_low_s;
    wire logic sample_now  = ~init_done | (en_fall & supply_5v_present) | soft_reset;

    wire logic [1:0] next_port_role =
        (role_s == TCCP_LVL_HIGH) ? TCCP_ROLE_SOURCE :
        (role_s == TCCP_LVL_OPEN) ? TCCP_ROLE_DUAL : TCCP_ROLE_SINK;
    wire logic       next_i2c_enable = (addr_s != TCCP_LVL_OPEN);
    wire logic [6:0] next_i2c_addr =
        (addr_s == TCCP_LVL_HIGH) ? TCCP_ADDR_STRAP_HIGH :
        (addr_s == TCCP_LVL_LOW)  ? TCCP_ADDR_STRAP_LOW  :
                                    TCCP_ADDR_RESET;

    // sample registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            en_low_prev     <= 1'b1;
            init_done       <= 1'b0;
            port_role       <= TCCP_ROLE_SINK;
            i2c_enable      <= 1'b0;
            i2c_target_addr <= TCCP_ADDR_RESET;
        end
        else
        begin
            en_low_prev <= en_low_s;
            init_done   <= 1'b1;
            if (sample_now)
            begin
                port_role       <= next_port_role;
                i2c_enable      <= next_i2c_enable;
                i2c_target_addr <= next_i2c_addr;
            end
        end
    end

    // =====================================================================
    // status decoding; sink status, audio and attach indications are gated by the enable
    wire logic gpio_mode   = ~i2c_enable;
    wire logic role_sink   = (port_role == TCCP_ROLE_SINK) |
                             ((port_role == TCCP_ROLE_DUAL) & ~cc_acting_source);
    wire logic next_active = ~en_low_s;

    // a dual-role port uses the strap only while it is sourcing
    wire logic [1:0] next_adv_current =
        (gpio_mode & ~role_sink & cur_s == TCCP_LVL_HIGH) ? TCCP_CUR_HIGH :
        (gpio_mode & ~role_sink & cur_s == TCCP_LVL_OPEN) ? TCCP_CUR_MEDIUM :
                                                            TCCP_CUR_DEFAULT;

    wire logic sink_status = gpio_mode & role_sink & cc_active;
    wire logic next_sda_oe = i2c_enable ? i2c_sda_drive_low :
        sink_status & (sink_current_level != TCCP_CUR_DEFAULT);
    wire logic next_scl_oe = i2c_enable ? i2c_scl_drive_low :
        sink_status & (sink_current_level == TCCP_CUR_HIGH);
    wire logic next_int_oe = i2c_enable ? reg_change_pending :
        audio_detected & cc_active;
    wire logic next_fault_oe  = cable_supply_overcurrent;
    // a fixed source is always sourcing, so only a dual-role port needs the source flag
    wire logic next_attach_oe = cc_active & cc_attach_detected & ~role_sink;

    // =====================================================================
    // output registers; open-drain pins only ever drive low or release
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cc_active                       <= 1'b0;
            advertise_current               <= TCCP_CUR_DEFAULT;
            sda_pin_oe                      <= 1'b0;
            scl_pin_oe                      <= 1'b0;
            audio_accessory_flag_oe         <= 1'b0;
            cable_supply_overcurrent_low_oe <= 1'b0;
            source_attach_low_oe            <= 1'b0;
        end
        else
        begin
            cc_active                       <= next_active;
            advertise_current               <= next_adv_current;
            sda_pin_oe                      <= next_sda_oe;
            scl_pin_oe                      <= next_scl_oe;
            audio_accessory_flag_oe         <= next_int_oe;
            cable_supply_overcurrent_low_oe <= next_fault_oe;
            source_attach_low_oe            <= next_attach_oe;
        end
    end

    // drive level is low whenever enabled; released state leaves the pull-up in charge
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sda_pin_out                      <= 1'b0;
            scl_pin_out                      <= 1'b0;
            audio_accessory_flag_out         <= 1'b0;
            cable_supply_overcurrent_low_out <= 1'b0;
            source_attach_low_out            <= 1'b0;
        end
        else
        begin
            sda_pin_out                      <= 1'b0;
            scl_pin_out                      <= 1'b0;
            audio_accessory_flag_out         <= 1'b0;
            cable_supply_overcurrent_low_out <= 1'b0;
            source_attach_low_out            <= 1'b0;
        end
    end

    // =====================================================================
    // assertions
    default clocking tccp_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    addr_high_a: assert property (init_done && sample_now && addr_s == TCCP_LVL_HIGH
        |=> i2c_enable && i2c_target_addr == 7'h67)
        else $error("strap high did not select address 0x67");
    addr_low_a: assert property (init_done && sample_now && addr_s == TCCP_LVL_LOW
        |=> i2c_enable && i2c_target_addr == 7'h47)
        else $error("strap low did not select address 0x47");
    gpio_mode_a: assert property (sample_now && addr_s == TCCP_LVL_OPEN
        |=> !i2c_enable)
        else $error("open strap did not select status mode");
    int_pin_a: assert property (i2c_enable && $rose(reg_change_pending)
        |=> audio_accessory_flag_oe && !audio_accessory_flag_out)
        else $error("interrupt pin not pulled low on register change");
    audio_pin_a: assert property (!i2c_enable && cc_active && audio_detected
        && $stable(i2c_enable) |=> audio_accessory_flag_oe)
        else $error("audio pin not pulled low on accessory");
    fault_pin_a: assert property (cable_supply_overcurrent
        |=> cable_supply_overcurrent_low_oe ##0 !cable_supply_overcurrent_low_out)
        else $error("fault pin not pulled low on overcurrent");
    bus_follow_a: assert property (i2c_enable && $stable(i2c_enable)
        |=> sda_pin_oe == $past(i2c_sda_drive_low)
            && scl_pin_oe == $past(i2c_scl_drive_low))
        else $error("bus pins do not follow the serial engine");
    status_a_a: assert property (sink_status && $stable(sink_status)
        |=> sda_pin_oe == ($past(sink_current_level) != TCCP_CUR_DEFAULT))
        else $error("first current status wrong");
    status_b_a: assert property (sink_status && sink_current_level == TCCP_CUR_MEDIUM
        && $stable(i2c_enable) |=> !scl_pin_oe)
        else $error("second current status low for medium current");
    attach_pin_a: assert property (source_attach_low_oe
        |-> $past(cc_attach_detected) && !$past(role_sink))
        else $error("source attach pin low without source attach");
    // enable pin to cc_active takes three edges through the synchroniser
    enable_a: assert property ($rose(cc_logic_enable_low) ##1 cc_logic_enable_low
        |-> ##2 !cc_active [*2])
        else $error("port logic active with enable released");
    role_a: assert property (soft_reset && role_s == TCCP_LVL_HIGH
        |=> port_role == TCCP_ROLE_SOURCE)
        else $error("role strap not sampled at soft reset");
    current_a: assert property (!i2c_enable && role_sink && $stable(port_role)
        && $stable(i2c_enable) |=> advertise_current == TCCP_CUR_DEFAULT)
        else $error("current strap used while sinking");

    i2c_mode_c: cover property (i2c_enable && audio_accessory_flag_oe);
    sink_high_c: cover property (sink_status && scl_pin_oe && sda_pin_oe);
    source_attach_c: cover property (source_attach_low_oe && advertise_current == TCCP_CUR_HIGH);
    fault_c: cover property (cable_supply_overcurrent_low_oe);

endmodule

`default_nettype wire

// >>> tccp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// board and system controller beside the pins: pull-ups plus a bus master
// that may hold the data or clock line low
module tccp_ctrl_model (
    input  wire logic sda_oe,
    input  wire logic sda_out,
    input  wire logic scl_oe,
    input  wire logic scl_out,
    input  wire logic flag_oe,
    input  wire logic flag_out,
    input  wire logic fault_oe,
    input  wire logic fault_out,
    input  wire logic attach_oe,
    input  wire logic attach_out,
    input  wire logic ctrl_sda_low,
    input  wire logic ctrl_scl_low,
    output wire logic sda_wire,
    output wire logic scl_wire,
    output wire logic flag_wire,
    output wire logic fault_wire,
    output wire logic attach_wire
);
    // wired-and of every party; a released line floats to the pull-up level
    assign sda_wire    = !((sda_oe && !sda_out) || ctrl_sda_low);
    assign scl_wire    = !((scl_oe && !scl_out) || ctrl_scl_low);
    assign flag_wire   = !(flag_oe && !flag_out);
    assign fault_wire  = !(fault_oe && !fault_out);
    assign attach_wire = !(attach_oe && !attach_out);
endmodule

`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import tccp_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, en_low = 1'b1, sup = 1'b0, srst = 1'b0;
    logic [1:0] addr_lv = 2'h0, role_lv = 2'h0, cur_lv = 2'h0, sink_cur = 2'h0;
    logic attach = 1'b0, act_src = 1'b0, audio = 1'b0, ovc = 1'b0, irq = 1'b0;
    logic sda_dl = 1'b0, scl_dl = 1'b0, c_sda = 1'b0, c_scl = 1'b0;
    wire logic sda_w, scl_w, flag_w, fault_w, att_w;
    logic sda_o, sda_oe, scl_o, scl_oe, fl_o, fl_oe, ft_o, ft_oe, at_o, at_oe;
    logic i2c_en, sda_i, scl_i, cc_act;
    logic [6:0] taddr;
    logic [1:0] role, adv;
    int fails = 0, n_compared = 0, i;
    logic [1:0] t_addr [3] = '{TCCP_LVL_HIGH, TCCP_LVL_LOW, TCCP_LVL_OPEN};
    logic [1:0] t_role [3] = '{TCCP_LVL_HIGH, TCCP_LVL_LOW, TCCP_LVL_OPEN};
    logic [6:0] x_addr [3] = '{7'h67, 7'h47, 7'h00};
    logic [1:0] x_role [3] = '{TCCP_ROLE_SOURCE, TCCP_ROLE_SINK, TCCP_ROLE_DUAL};

    always #2.5 clk_sys = ~clk_sys;

    tccp_pins dut_u (.clk_sys(clk_sys), .rst(rst), .addr_strap_level(addr_lv),
        .role_strap_level(role_lv), .current_strap_level(cur_lv), .cc_logic_enable_low(en_low),
        .supply_5v_present(sup), .soft_reset(srst), .cc_attach_detected(attach),
        .cc_acting_source(act_src), .audio_detected(audio), .sink_current_level(sink_cur),
        .cable_supply_overcurrent(ovc), .reg_change_pending(irq), .i2c_sda_drive_low(sda_dl),
        .i2c_scl_drive_low(scl_dl), .sda_pin_in(sda_w), .sda_pin_out(sda_o),
        .sda_pin_oe(sda_oe), .scl_pin_in(scl_w), .scl_pin_out(scl_o), .scl_pin_oe(scl_oe),
        .audio_accessory_flag_out(fl_o), .audio_accessory_flag_oe(fl_oe),
        .cable_supply_overcurrent_low_out(ft_o), .cable_supply_overcurrent_low_oe(ft_oe),
        .source_attach_low_out(at_o), .source_attach_low_oe(at_oe), .i2c_enable(i2c_en),
        .i2c_target_addr(taddr), .i2c_sda_in(sda_i), .i2c_scl_in(scl_i), .cc_active(cc_act),
        .port_role(role), .advertise_current(adv));

    tccp_ctrl_model partner_u (.sda_oe(sda_oe), .sda_out(sda_o), .scl_oe(scl_oe),
        .scl_out(scl_o), .flag_oe(fl_oe), .flag_out(fl_o), .fault_oe(ft_oe), .fault_out(ft_o),
        .attach_oe(at_oe), .attach_out(at_o), .ctrl_sda_low(c_sda), .ctrl_scl_low(c_scl),
        .sda_wire(sda_w), .scl_wire(scl_w), .flag_wire(flag_w), .fault_wire(fault_w),
        .attach_wire(att_w));

    // =====================================================================
    // shared helpers
    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // settle a few cycles, then look at the mid-cycle values
    task automatic settle();
        cy(5);
        @(negedge clk_sys);
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // address and role straps only count once re-sampled, so every change ends with a soft reset pulse
    task automatic strap(input logic [1:0] a, input logic [1:0] r);
        cy(1);
        addr_lv <= a;
        role_lv <= r;
        cy(4);
        srst <= 1'b1;
        cy(1);
        srst <= 1'b0;
        settle();
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog: the sequence needs well under 1000 cycles
    initial
    begin
        #20000;
        fails++;
        complete_run();
    end

    // =====================================================================
    // main sequence
    initial
    begin
        cy(6);
        rst <= 1'b0;
        cy(3);
        for (i = 0; i < 3; i++)
        begin
            strap(t_addr[i], t_role[i]);
            check("i2c_enable", i2c_en, {7'h0, i < 2});
            check("target_addr", taddr, x_addr[i]);
            check("port_role", role, x_role[i]);
        end
        // enable fall without the 5 V supply must not re-sample the role
        strap(TCCP_LVL_HIGH, TCCP_LVL_HIGH);
        cy(1);
        role_lv <= TCCP_LVL_LOW;
        en_low <= 1'b0;
        settle();
        check("role_nosupply", role, TCCP_ROLE_SOURCE);
        check("cc_active_on", cc_act, 1'b1);
        cy(1);
        en_low <= 1'b1;
        settle();
        check("cc_active_off", cc_act, 1'b0);
        cy(1);
        sup <= 1'b1;
        en_low <= 1'b0;
        settle();
        check("role_enfall", role, TCCP_ROLE_SINK);
        // status mode as sink: current level pins, audio and attach gating
        strap(TCCP_LVL_OPEN, TCCP_LVL_LOW);
        for (i = 0; i < 3; i++)
        begin
            cy(1);
            sink_cur <= i[1:0];
            settle();
            check("status_a", sda_w, {7'h0, i == 0});
            check("status_b", scl_w, {7'h0, i != 2});
        end
        cy(1);
        audio <= 1'b1;
        cur_lv <= TCCP_LVL_HIGH;
        attach <= 1'b1;
        ovc <= 1'b1;
        settle();
        check("audio_low", flag_w, 1'b0);
        check("adv_sink", adv, TCCP_CUR_DEFAULT);
        check("attach_sink", att_w, 1'b1);
        check("fault_low", fault_w, 1'b0);
        cy(1);
        audio <= 1'b0;
        ovc <= 1'b0;
        settle();
        check("audio_rel", flag_w, 1'b1);
        check("fault_rel", fault_w, 1'b1);
        // source role: attach pin and advertised current per strap
        strap(TCCP_LVL_OPEN, TCCP_LVL_HIGH);
        check("attach_src", att_w, 1'b0);
        for (i = 0; i < 3; i++)
        begin
            cy(1);
            cur_lv <= i[1:0];
            settle();
            check("adv_src", adv, i[7:0]);
        end
        strap(TCCP_LVL_OPEN, TCCP_LVL_OPEN);
        check("attach_dual_snk", att_w, 1'b1);
        cy(1);
        act_src <= 1'b1;
        settle();
        check("attach_dual", att_w, 1'b0);
        // serial control mode: interrupt pin and bus lines in both directions
        strap(TCCP_LVL_LOW, TCCP_LVL_HIGH);
        cy(1);
        irq <= 1'b1;
        sda_dl <= 1'b1;
        c_scl <= 1'b1;
        settle();
        check("irq_low", flag_w, 1'b0);
        check("sda_drive", sda_w, 1'b0);
        check("scl_seen", scl_i, 1'b0);
        cy(1);
        irq <= 1'b0;
        sda_dl <= 1'b0;
        c_scl <= 1'b0;
        c_sda <= 1'b1;
        settle();
        check("irq_rel", flag_w, 1'b1);
        check("sda_seen", sda_i, 1'b0);
        check("scl_rel", scl_i, 1'b1);
        complete_run();
    end
endmodule

`default_nettype wire
